// *** include/exception_arbiter_pkg.sv ***
// package: constants and carrier types of the exception arbiter
package exception_arbiter_pkg;
  // -------------------------------------------------------------
  // register map (word aligned byte offsets)
  // -------------------------------------------------------------
  localparam logic [3:0] OFS_PEND_LOW = 4'h0;
  localparam logic [3:0] OFS_PEND_HIGH = 4'h4;
  localparam logic [3:0] OFS_PEND_SPARE = 4'h8;
  localparam logic [3:0] OFS_BRK_CTRL = 4'hC;
  localparam int PEND_LOW_LSB = 2;        // first flag sits at bit 2
  localparam int BREAK_CLEAR_ENABLE_BIT = 0;
  localparam logic BREAK_CLEAR_ENABLE_RESET = 1'b0;
  // -------------------------------------------------------------
  // priorities and vector low bytes
  // -------------------------------------------------------------
  localparam int NUM_PRIO = 11;           // hardware priorities 1..11
  localparam logic [7:0] VEC_RESET_LO = 8'hFE;
  localparam logic [7:0] VEC_SWI_LO = 8'hFC;  // priority 0
  localparam logic [7:0] VEC_STEP = 8'h02;    // one vector pair per priority
  localparam logic [7:0] VEC_CODE_RESET = 8'h00;
  localparam int NUM_RESET_SRC = 5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ENTRY = 2'b10
  } arb_state_t;

  typedef struct packed {
    logic extPin;
    logic frameStart;
    logic frameEndPoint;
    logic packetEnd;
    logic busTransition;
    logic hubCtrlTx;
    logic hubCtrlRx;
    logic devCtrlTx;
    logic devCtrlRx;
    logic devEp12Tx;
    logic capture0;
    logic capture1;
    logic counterWrap;
    logic kbdE;
    logic kbdD;
    logic kbdF;
    logic synthLock;
  } src_flags_t;

  typedef struct packed {
    logic instrDone;    // instruction boundary pulse
    logic swiExec;      // software trap instruction completing
    logic rtiExec;      // return from handler completing
    logic globalMask;   // core's global interrupt mask
    logic vecTaken;     // core fetched the vector
    logic breakReq;     // break module request
  } core_in_t;

  typedef struct packed {
    logic entryReq;     // interrupt/reset entry requested
    logic [7:0] vecCode;
    logic pcMinusOne;   // stack pc-1 (hardware) or pc (trap)
    logic saveState;    // push core state (index high excluded)
    logic setMask;      // pulse: set global mask
    logic restoreState; // pulse: pull core state
    logic breakState;
    logic clearAllowed; // peripherals may clear status flags
  } core_out_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
endpackage

// *** design/exception_arbiter.sv ***
// exception arbiter: request latch, fixed priority, break and status registers

// Contract
// - latch requests, arbitrate, output vector select code
// - latched request keeps precedence until serviced; a hardware one is withdrawn if the global mask sets before the fetch
// - non-reset entry saves state; every entry sets global mask
// - return instruction restores saved core state
// - hardware requests wait for instruction completion
// - take request only if unmasked and enabled
// - lowest priority number wins among pending
// - still pending after return is serviced next
// - entry never pushes the index high register
// - software trap ignores mask, priority zero vector
// - trap stacks pc, hardware stacks pc minus one
// - four hub frame events share priority two
// - hub control tx/rx share priority three
// - device control and ep12 tx share four
// - keyboard ports e, d, f at eight-ten
// - status flags mirror requests, spare bits zero
// - any reset source wins, no arbitration
// - break forces the software trap vector
// - break without enable blocks flag clearing
// - enable set lets clearing work in break
// - two-step clears stay blocked during break
// - break clear enable is read/write bit
module exception_arbiter (
  input wire logic core_clk,                                  // system bus clock
  input wire logic rst,                                       // async reset, high
  input wire logic [exception_arbiter_pkg::NUM_RESET_SRC-1:0] resetSrc, // reset sources
  input wire exception_arbiter_pkg::src_flags_t srcFlags,     // peripheral flags
  input wire exception_arbiter_pkg::src_flags_t srcEnables,   // peripheral enables
  input wire exception_arbiter_pkg::core_in_t coreIn,         // core handshake
  output exception_arbiter_pkg::core_out_t coreOut,           // to core
  input wire exception_arbiter_pkg::wb_req_t wbReq,           // wishbone request
  output logic [31:0] wbDatR,                                 // wishbone read data
  output logic wbAck                                          // wishbone ack
);
  localparam int NP = exception_arbiter_pkg::NUM_PRIO;

  typedef struct packed {
    exception_arbiter_pkg::arb_state_t st;
    logic isReset;
    logic break_clear_enable;
    logic ack;
    logic [31:0] rdata;
    exception_arbiter_pkg::core_out_t co;
  } state_t;

  state_t q;
  state_t d;

  // -------------------------------------------------------------
  // grouping of sources onto priorities 1..11 (index 0 = priority 1)
  // -------------------------------------------------------------
  exception_arbiter_pkg::src_flags_t act;
  logic [NP-1:0] pend;
  assign act = srcFlags & srcEnables;
  assign pend[0] = act.extPin;
  assign pend[1] = act.frameStart | act.frameEndPoint
                 | act.packetEnd | act.busTransition;
  assign pend[2] = act.hubCtrlTx | act.hubCtrlRx;
  assign pend[3] = act.devCtrlTx | act.devCtrlRx | act.devEp12Tx;
  assign pend[4] = act.capture0;
  assign pend[5] = act.capture1;
  assign pend[6] = act.counterWrap;
  assign pend[7] = act.kbdE;
  assign pend[8] = act.kbdD;
  assign pend[9] = act.kbdF;
  assign pend[10] = act.synthLock;

  // -------------------------------------------------------------
  // fixed priority pick, lowest index wins
  // -------------------------------------------------------------
  logic [NP-1:0] below;   // below[i]: some lower index is pending
  logic [NP-1:0] win;
  logic [7:0] winCode [NP];
  logic [7:0] hwCode;
  genvar gi;
  assign below[0] = 1'b0;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pick
      if (gi > 0) begin : g_chain
        assign below[gi] = below[gi-1] | pend[gi-1];
      end
      assign win[gi] = pend[gi] & ~below[gi];
      assign winCode[gi] = win[gi] ?
        8'(exception_arbiter_pkg::VEC_SWI_LO
           - exception_arbiter_pkg::VEC_STEP * 8'(gi + 1)) : 8'h00;
    end
  endgenerate

  always_comb begin
    hwCode = 8'h00;
    for (int i = 0; i < NP; i++) begin
      hwCode = hwCode | winCode[i];
    end
  end

  logic anyPend;
  logic anyReset;
  logic wbHit;
  logic [31:0] rdMux;
  assign anyPend = |pend;
  assign anyReset = |resetSrc;
  assign wbHit = wbReq.cyc & wbReq.stb & ~q.ack;

  // -------------------------------------------------------------
  // register read mux
  // -------------------------------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (wbReq.adr)
      exception_arbiter_pkg::OFS_PEND_LOW:
        rdMux[exception_arbiter_pkg::PEND_LOW_LSB +: 6] = pend[5:0];
      exception_arbiter_pkg::OFS_PEND_HIGH:
        rdMux[4:0] = pend[10:6];
      exception_arbiter_pkg::OFS_BRK_CTRL:
        rdMux[exception_arbiter_pkg::BREAK_CLEAR_ENABLE_BIT] = q.break_clear_enable;
      default:
        rdMux = 32'h0000_0000;  // spare register and holes read zero
    endcase
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    d = q;
    d.co.setMask = 1'b0;
    d.co.restoreState = 1'b0;
    // bus slave: one wait state, ack dropped the cycle after
    d.ack = wbHit;
    if (wbHit) begin
      d.rdata = wbReq.we ? 32'h0000_0000 : rdMux;
      // only the control bit is writable; status writes vanish
      if (wbReq.we && wbReq.adr == exception_arbiter_pkg::OFS_BRK_CTRL
          && wbReq.sel[0]) begin
        d.break_clear_enable = wbReq.dat[exception_arbiter_pkg::BREAK_CLEAR_ENABLE_BIT];
      end
    end
    if (coreIn.rtiExec) begin
      d.co.restoreState = 1'b1;
      d.co.breakState = 1'b0;
    end
    unique case (q.st)
      exception_arbiter_pkg::ST_IDLE: begin
        if (coreIn.instrDone) begin
          if (coreIn.swiExec || coreIn.breakReq) begin
            // trap and break bypass the mask
            d.st = exception_arbiter_pkg::ST_ENTRY;
            d.co.vecCode = exception_arbiter_pkg::VEC_SWI_LO;
            d.co.pcMinusOne = ~coreIn.swiExec;
            d.co.breakState = coreIn.breakReq;
          end else if (!coreIn.globalMask && anyPend) begin
            d.st = exception_arbiter_pkg::ST_ENTRY;
            d.co.vecCode = hwCode;
            d.co.pcMinusOne = 1'b1;
          end
        end
      end
      exception_arbiter_pkg::ST_ENTRY: begin
        // latched code frozen: newer hardware and trap requests cannot displace it, a reset source can
        if (coreIn.vecTaken) begin
          d.st = exception_arbiter_pkg::ST_IDLE;
          d.co.setMask = 1'b1;
        end else if (coreIn.globalMask && !q.isReset
                     && q.co.pcMinusOne && !q.co.breakState) begin
          d.st = exception_arbiter_pkg::ST_IDLE;
        end
      end
    endcase
    d.isReset = 1'b0;
    if (anyReset) begin
      // every source alike, taken at once, above all else
      d.st = exception_arbiter_pkg::ST_ENTRY;
      d.isReset = 1'b1;
      d.co.vecCode = exception_arbiter_pkg::VEC_RESET_LO;
      d.co.pcMinusOne = 1'b0;
      d.co.breakState = 1'b0;
      d.break_clear_enable = exception_arbiter_pkg::BREAK_CLEAR_ENABLE_RESET;
    end else if (q.isReset && q.st == exception_arbiter_pkg::ST_ENTRY
                 && !coreIn.vecTaken) begin
      d.isReset = 1'b1;
    end
    d.co.entryReq = d.st == exception_arbiter_pkg::ST_ENTRY;
    // state push excludes the index high register by design
    d.co.saveState = d.co.entryReq & ~d.isReset;
    // a peripheral gates both steps of a two-step clear with this
    // level, so a first step taken before break still cannot finish
    d.co.clearAllowed = ~d.co.breakState | d.break_clear_enable;
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '{st: exception_arbiter_pkg::ST_IDLE, isReset: 1'b0,
             break_clear_enable: exception_arbiter_pkg::BREAK_CLEAR_ENABLE_RESET, ack: 1'b0,
             rdata: 32'h0000_0000,
             co: '{entryReq: 1'b0, vecCode: exception_arbiter_pkg::VEC_CODE_RESET,
                   pcMinusOne: 1'b0, saveState: 1'b0, setMask: 1'b0,
                   restoreState: 1'b0, breakState: 1'b0, clearAllowed: 1'b1}};
    end else begin
      q <= d;
    end
  end

  assign coreOut = q.co;
  assign wbDatR = q.rdata;
  assign wbAck = q.ack;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_hwTake;
    coreIn.instrDone && !coreIn.swiExec && !coreIn.breakReq && !coreIn.globalMask
      && anyPend && !anyReset && q.st == exception_arbiter_pkg::ST_IDLE;
  endsequence

  property p_hwEntry;
    s_hwTake |=> coreOut.entryReq && coreOut.pcMinusOne && coreOut.vecCode == $past(hwCode);
  endproperty
  a_hwEntry: assert property (p_hwEntry) else $error("hw entry wrong");

  property p_latchHolds;
    coreOut.entryReq && !coreIn.vecTaken && !anyReset && !coreIn.globalMask
      |=> $stable(coreOut.vecCode) && coreOut.entryReq;
  endproperty
  a_latchHolds: assert property (p_latchHolds) else $error("latch moved");

  property p_maskSet;
    coreOut.entryReq && coreIn.vecTaken && !anyReset |=> coreOut.setMask ##1 !coreOut.setMask;
  endproperty
  a_maskSet: assert property (p_maskSet) else $error("mask not set");

  property p_restore;
    coreIn.rtiExec |=> coreOut.restoreState;
  endproperty
  a_restore: assert property (p_restore) else $error("no restore");

  property p_noMidInstr;
    !coreOut.entryReq && !coreIn.instrDone && !anyReset |=> !coreOut.entryReq;
  endproperty
  a_noMidInstr: assert property (p_noMidInstr) else $error("entry mid instr");

  property p_masked;
    coreIn.instrDone && coreIn.globalMask && !coreIn.swiExec && !coreIn.breakReq
      && !anyReset && !coreOut.entryReq |=> !coreOut.entryReq;
  endproperty
  a_masked: assert property (p_masked) else $error("masked taken");

  property p_swi;
    coreIn.instrDone && coreIn.swiExec && !anyReset && !coreOut.entryReq
      |=> coreOut.vecCode == exception_arbiter_pkg::VEC_SWI_LO && !coreOut.pcMinusOne;
  endproperty
  a_swi: assert property (p_swi) else $error("trap vector wrong");

  property p_reset;
    anyReset |=> coreOut.entryReq && coreOut.vecCode == exception_arbiter_pkg::VEC_RESET_LO;
  endproperty
  a_reset: assert property (p_reset) else $error("reset lost");

  property p_break;
    coreIn.instrDone && coreIn.breakReq && !anyReset && !coreOut.entryReq
      |=> coreOut.breakState && coreOut.vecCode == exception_arbiter_pkg::VEC_SWI_LO;
  endproperty
  a_break: assert property (p_break) else $error("break not forced");

  property p_protect;
    coreOut.breakState && !q.break_clear_enable |-> !coreOut.clearAllowed;
  endproperty
  a_protect: assert property (p_protect) else $error("flags unprotected");

  property p_ack;
    wbReq.cyc && wbReq.stb && !wbAck |=> wbAck ##1 !wbAck;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing");

  property p_saveOnEntry;
    s_hwTake |=> coreOut.saveState;
  endproperty
  a_saveOnEntry: assert property (p_saveOnEntry) else $error("no state push");

  property p_oneWinner;
    anyPend |-> $onehot(win);
  endproperty
  a_oneWinner: assert property (p_oneWinner) else $error("winner not unique");

  property p_topWins;
    pend[0] |-> hwCode == exception_arbiter_pkg::VEC_SWI_LO - exception_arbiter_pkg::VEC_STEP;
  endproperty
  a_topWins: assert property (p_topWins) else $error("priority one lost");

  property p_prio2;
    pend[1] && !pend[0] |-> hwCode == 8'hF8;
  endproperty
  a_prio2: assert property (p_prio2) else $error("frame group vector wrong");

  property p_prio3;
    pend[2] && !(|pend[1:0]) |-> hwCode == 8'hF6;
  endproperty
  a_prio3: assert property (p_prio3) else $error("hub control vector wrong");

  property p_prio4;
    pend[3] && !(|pend[2:0]) |-> hwCode == 8'hF4;
  endproperty
  a_prio4: assert property (p_prio4) else $error("device control vector wrong");

  property p_prio8;
    pend[7] && !(|pend[6:0]) |-> hwCode == 8'hEC;
  endproperty
  a_prio8: assert property (p_prio8) else $error("keyboard vector wrong");

  property p_statLow;
    wbHit && !wbReq.we && wbReq.adr == exception_arbiter_pkg::OFS_PEND_LOW
      |=> wbDatR == {24'h00_0000, $past(pend[5:0]), 2'h0};
  endproperty
  a_statLow: assert property (p_statLow) else $error("low status wrong");

  property p_statHigh;
    wbHit && !wbReq.we && wbReq.adr == exception_arbiter_pkg::OFS_PEND_HIGH
      |=> wbDatR == {27'h000_0000, $past(pend[10:6])};
  endproperty
  a_statHigh: assert property (p_statHigh) else $error("high status wrong");

  property p_spare;
    wbHit && !wbReq.we && wbReq.adr == exception_arbiter_pkg::OFS_PEND_SPARE
      |=> wbDatR == 32'h0000_0000;
  endproperty
  a_spare: assert property (p_spare) else $error("spare status not zero");

  property p_bcfeWrite;
    wbHit && wbReq.we && wbReq.adr == exception_arbiter_pkg::OFS_BRK_CTRL && wbReq.sel[0]
      && !anyReset |=> q.break_clear_enable == $past(wbReq.dat[exception_arbiter_pkg::BREAK_CLEAR_ENABLE_BIT]);
  endproperty
  a_bcfeWrite: assert property (p_bcfeWrite) else $error("control bit not written");

  property p_statWrite;
    wbHit && wbReq.we && wbReq.adr != exception_arbiter_pkg::OFS_BRK_CTRL && !anyReset
      |=> $stable(q.break_clear_enable) && wbDatR == 32'h0000_0000;
  endproperty
  a_statWrite: assert property (p_statWrite) else $error("status write took effect");

  property p_clearOpen;
    coreOut.breakState && q.break_clear_enable |-> coreOut.clearAllowed;
  endproperty
  a_clearOpen: assert property (p_clearOpen) else $error("clearing blocked");

  property p_clearAfter;
    !coreOut.breakState |-> coreOut.clearAllowed;
  endproperty
  a_clearAfter: assert property (p_clearAfter) else $error("clearing blocked outside break");
endmodule

// *** bench/core_model.sv ***
// behavioural processor core that fetches the vector after an entry request
module core_model (
  input wire logic core_clk,                             // system bus clock
  input wire logic rst,                                  // async reset, high
  input wire exception_arbiter_pkg::core_out_t coreOut,  // arbiter outputs
  input wire logic slow,                                 // 1 = late vector fetch
  output logic vecTaken,                                 // one-cycle fetch pulse
  output logic [7:0] takenVec                            // code seen at the fetch
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] waitCnt;
  // -------------------------------------------------------------
  // vector fetch
  // -------------------------------------------------------------
  // a slow fetch leaves the request standing so late requests can try to overtake it
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vecTaken <= 1'b0;
      waitCnt <= 4'h0;
      takenVec <= 8'h00;
    end else if (vecTaken) begin
      vecTaken <= 1'b0;
      takenVec <= coreOut.vecCode;
    end else if (coreOut.entryReq) begin
      if (waitCnt >= (slow ? 4'h5 : 4'h0)) begin
        vecTaken <= 1'b1;
        waitCnt <= 4'h0;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule

// *** bench/tb_top.sv ***
// top-level bench: arbitration table, reset, latch, break and register tests
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [16:0] flags;
    logic [2:0] ctl;
    logic expEntry;
    logic [7:0] expVec;
    logic expPcm;
  } row_t;
  logic core_clk, rst, instrDone, swiExec, rtiExec, globalMask, breakReq, slow, vecTaken;
  logic [4:0] resetSrc;
  logic [16:0] flags, enables;
  logic [7:0] takenVec;
  logic [31:0] wbDatR, rd;
  logic wbAck;
  int mismatches, numChecks;
  exception_arbiter_pkg::core_in_t coreIn;
  exception_arbiter_pkg::core_out_t coreOut;
  exception_arbiter_pkg::wb_req_t wbReq;
  // ctl holds mask, trap and enable
  row_t rows [22] = '{
    '{17'h10000, 3'h1, 1'b1, 8'hFA, 1'b1}, '{17'h08000, 3'h1, 1'b1, 8'hF8, 1'b1},
    '{17'h04000, 3'h1, 1'b1, 8'hF8, 1'b1}, '{17'h02000, 3'h1, 1'b1, 8'hF8, 1'b1},
    '{17'h01000, 3'h1, 1'b1, 8'hF8, 1'b1}, '{17'h00800, 3'h1, 1'b1, 8'hF6, 1'b1},
    '{17'h00400, 3'h1, 1'b1, 8'hF6, 1'b1}, '{17'h00200, 3'h1, 1'b1, 8'hF4, 1'b1},
    '{17'h00100, 3'h1, 1'b1, 8'hF4, 1'b1}, '{17'h00080, 3'h1, 1'b1, 8'hF4, 1'b1},
    '{17'h00008, 3'h1, 1'b1, 8'hEC, 1'b1}, '{17'h00004, 3'h1, 1'b1, 8'hEA, 1'b1},
    '{17'h00002, 3'h1, 1'b1, 8'hE8, 1'b1}, '{17'h00001, 3'h1, 1'b1, 8'hE6, 1'b1},
    '{17'h0000E, 3'h1, 1'b1, 8'hEC, 1'b1}, '{17'h10008, 3'h1, 1'b1, 8'hFA, 1'b1},
    '{17'h10000, 3'h5, 1'b0, 8'h00, 1'b1}, '{17'h10000, 3'h0, 1'b0, 8'h00, 1'b1},
    '{17'h10000, 3'h7, 1'b1, 8'hFC, 1'b0}, '{17'h00040, 3'h1, 1'b1, 8'hF2, 1'b1},
    '{17'h00020, 3'h1, 1'b1, 8'hF0, 1'b1}, '{17'h00010, 3'h1, 1'b1, 8'hEE, 1'b1}};
  assign coreIn = {instrDone, swiExec, rtiExec, globalMask, vecTaken, breakReq};
  exception_arbiter u_exception_arbiter (.core_clk(core_clk), .rst(rst), .resetSrc(resetSrc),
    .srcFlags(flags), .srcEnables(enables), .coreIn(coreIn), .coreOut(coreOut),
    .wbReq(wbReq), .wbDatR(wbDatR), .wbAck(wbAck));
  core_model u_core_model (.core_clk(core_clk), .rst(rst), .coreOut(coreOut), .slow(slow),
    .vecTaken(vecTaken), .takenVec(takenVec));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic test_done(input bit hung);
    if (hung) mismatches++;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wdat,
                    output logic [31:0] rdat);
    int n;
    @(posedge core_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wdat};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rdat = wbDatR;
    wbReq <= '0;
    if (n >= 20) test_done(1'b1);
  endtask
  task automatic boundary();
    @(posedge core_clk);
    instrDone <= 1'b1;
    @(posedge core_clk);
    instrDone <= 1'b0;
    #1;
  endtask
  task automatic return_from_handler_instr();
    @(posedge core_clk);
    rtiExec <= 1'b1;
    @(posedge core_clk);
    rtiExec <= 1'b0;
    #1;
  endtask
  // waits out the fetch; the mask pulse lands as the request drops
  task automatic take_vector(input logic chkMask);
    int n;
    n = 0;
    while (coreOut.entryReq === 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 40) test_done(1'b1);
    if (chkMask) chk1("setMask", 1'b1, coreOut.setMask);
  endtask
  // -------------------------------------------------------------
  // stimulus
  // -------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {instrDone, swiExec, rtiExec, globalMask, breakReq, slow} = '0;
    resetSrc = '0;
    flags = '0;
    enables = '0;
    wbReq = '0;
    repeat (7) @(posedge core_clk);
    #1;
    chk1("rstEntry", 1'b0, coreOut.entryReq);
    chk("rstVec", 32'h0, coreOut.vecCode);
    chk1("rstClear", 1'b1, coreOut.clearAllowed);
    @(posedge core_clk);
    rst <= 1'b0;
    wb(1'b0, 4'hC, 32'h0, rd);
    chk("brkCtrlReset", 32'h0, rd);
    foreach (rows[i]) begin
      @(posedge core_clk);
      flags <= rows[i].flags;
      enables <= {17{rows[i].ctl[0]}};
      globalMask <= rows[i].ctl[2];
      swiExec <= rows[i].ctl[1];
      boundary();
      chk1("entryReq", rows[i].expEntry, coreOut.entryReq);
      if (rows[i].expEntry) begin
        chk("vecCode", rows[i].expVec, coreOut.vecCode);
        chk1("pcMinusOne", rows[i].expPcm, coreOut.pcMinusOne);
        chk1("saveState", 1'b1, coreOut.saveState);
        take_vector(1'b1);
      end
    end
    // a reset source raised a cycle before the boundary is taken ahead of the pending hardware request
    for (int i = 0; i < exception_arbiter_pkg::NUM_RESET_SRC; i++) begin
      @(posedge core_clk);
      swiExec <= 1'b0;
      globalMask <= 1'b0;
      resetSrc <= 5'h01 << i;
      @(posedge core_clk);
      instrDone <= 1'b1;
      @(posedge core_clk);
      instrDone <= 1'b0;
      resetSrc <= 5'h00;
      #1;
      chk("resetVec", 32'hFE, coreOut.vecCode);
      chk1("resetSave", 1'b0, coreOut.saveState);
      take_vector(1'b0);
    end
    @(posedge core_clk);
    slow <= 1'b1;
    flags <= 17'h00002;
    @(posedge core_clk);
    #1;
    chk1("noEntryMidInstr", 1'b0, coreOut.entryReq);
    boundary();
    chk("vecLow", 32'hE8, coreOut.vecCode);
    @(posedge core_clk);
    flags <= 17'h10002;
    take_vector(1'b1);
    chk("latchedVec", 32'hE8, takenVec);
    return_from_handler_instr();
    chk1("restoreState", 1'b1, coreOut.restoreState);
    slow <= 1'b0;
    boundary();
    chk("pendingNext", 32'hFA, coreOut.vecCode);
    take_vector(1'b1);
    @(posedge core_clk);
    flags <= 17'h0;
    breakReq <= 1'b1;
    boundary();
    chk("breakVec", 32'hFC, coreOut.vecCode);
    chk1("breakState", 1'b1, coreOut.breakState);
    @(posedge core_clk);
    breakReq <= 1'b0;
    take_vector(1'b1);
    chk1("clearBlocked", 1'b0, coreOut.clearAllowed);
    wb(1'b1, 4'hC, 32'h1, rd);
    @(posedge core_clk);
    #1;
    chk1("clearInBreak", 1'b1, coreOut.clearAllowed);
    wb(1'b0, 4'hC, 32'h0, rd);
    chk("brkCtrlRead", 32'h1, rd);
    return_from_handler_instr();
    chk1("breakEnd", 1'b0, coreOut.breakState);
    @(posedge core_clk);
    flags <= 17'h1FFFF;
    enables <= 17'h1FFFF;
    wb(1'b0, 4'h0, 32'h0, rd);
    chk("pendLow", 32'hFC, rd);
    wb(1'b0, 4'h4, 32'h0, rd);
    chk("pendHigh", 32'h1F, rd);
    wb(1'b0, 4'h8, 32'h0, rd);
    chk("pendSpare", 32'h0, rd);
    enables <= 17'h08024;
    wb(1'b1, 4'h0, 32'hFF, rd);
    wb(1'b0, 4'h0, 32'h0, rd);
    chk("pendLowPart", 32'h88, rd);
    wb(1'b0, 4'h4, 32'h0, rd);
    chk("pendHighPart", 32'h04, rd);
    wb(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    // reset again in mid-run: latched vector and control bit return to reset values
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk1("midRstEntry", 1'b0, coreOut.entryReq);
    chk("midRstVec", 32'h0, coreOut.vecCode);
    @(posedge core_clk);
    rst <= 1'b0;
    wb(1'b0, 4'hC, 32'h0, rd);
    chk("midRstBrkCtrl", 32'h0, rd);
    test_done(1'b0);
  end
endmodule
